// ===== common/codec_timing_pkg.sv
// Shared constants, register map and frame states of the codec timing block.
// Assumes a 200 MHz master clock and a 32-bit APB register bus.
package codec_timing_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Clocking and rate figures
  localparam int MCLK_HZ = 200000000;
  localparam int SCLK_DIV = 4;
  localparam int PHASE_W = $clog2(SCLK_DIV);
  localparam int MCLK_REF_HZ = 5184000;
  localparam int CONV_HZ = 8000;
  localparam int CNT_A_DEF = 18;
  localparam int CNT_B_DEF = MCLK_REF_HZ / CONV_HZ / CNT_A_DEF;
  localparam int CNT_W = 8;
  localparam int ADJ_W = 6;
  localparam int CTRL_W = 8;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [CNT_W-1:0] RST_CNT_A = CNT_W'(CNT_A_DEF);
  localparam logic [CNT_W-1:0] RST_CNT_B = CNT_W'(CNT_B_DEF);
  localparam logic [ADJ_W-1:0] RST_ADJ = 6'h01;
  localparam logic [CTRL_W-1:0] RST_CTRL = 8'he4;
  localparam int CTRL_SYNC_BIT = 5;

  //////////////////////////////////////////////////////////////////////////////
  // Frame shape, in shift clocks
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int GAP_SCLK = 4;
  localparam int BCNT_W = 5;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFF_TX_CNT_A = 8'h00;
  localparam logic [APB_AW-1:0] OFF_TX_ADJ = 8'h04;
  localparam logic [APB_AW-1:0] OFF_TX_CNT_B = 8'h08;
  localparam logic [APB_AW-1:0] OFF_RX_CNT_A = 8'h0c;
  localparam logic [APB_AW-1:0] OFF_RX_ADJ = 8'h10;
  localparam logic [APB_AW-1:0] OFF_RX_CNT_B = 8'h14;
  localparam logic [APB_AW-1:0] OFF_CTRL = 8'h18;
  localparam logic [APB_AW-1:0] OFF_ADJ_CMD = 8'h1c;
  localparam logic [APB_AW-1:0] OFF_OUT_WORD = 8'h20;
  localparam logic [APB_AW-1:0] OFF_IN_WORD = 8'h24;
  localparam logic [APB_AW-1:0] OFF_STATUS = 8'h28;
  localparam int ST_IN_NEW = 0;
  localparam int ST_UNDERRUN = 1;
  localparam int ST_BUF_FULL = 2;
  localparam int ST_WORD_PIN = 3;

  // Frame sequencer states, Gray along the usual path
  typedef enum logic [2:0] {
    FR_IDLE = 3'h0,
    FR_PRE = 3'h1,
    FR_SHIFT1 = 3'h3,
    FR_GAP = 3'h2,
    FR_SHIFT2 = 3'h6,
    FR_EOD = 3'h7
  } frame_state_t;

endpackage

// ===== logic/stream_buffer.sv
// Small valid/ready buffer for words queued toward the serial link.
// Assumes DEPTH is a power of two and a reset already synchronised.
`timescale 1ns/1ps
module stream_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
  logic [WIDTH-1:0] mem_next [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count_reg, count_next;
  logic push, pop;

  ////////////////////////////////////////////////////////////////////////////
  // Honest flags straight from the fill count
  assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Next pointers, count and contents
  always_comb begin
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_data_i;
      wr_ptr_next = wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = rd_ptr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // Storage frozen while the enable is low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (en_i) begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end
endmodule

// ===== logic/codec_serial_timing_reset.sv
// Timing, reset and serial frame logic of the analog interface device.
// Assumes a 200 MHz master clock, an APB master, and a host serial port on the link.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module codec_serial_timing_reset #(
  parameter int BUF_DEPTH = 2
) (
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [codec_timing_pkg::APB_AW-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic WORD_MODE_I,
  input wire logic TX_SERIAL_IN_I,
  output logic SHIFT_CLK_O,
  output logic TX_FRAME_SYNC_N_O,
  output logic RX_FRAME_SYNC_N_O,
  output logic RX_SERIAL_OUT_O,
  output logic TX_END_OF_DATA_N_O,
  output logic RX_END_OF_DATA_N_O,
  output logic FILTER_CLK_O,
  output logic DAC_STROBE_O,
  output logic ADC_STROBE_O
);
  import codec_timing_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Reset: asserts at once, releases two master clocks later
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read
  logic [1:0] dx_sync_reg, wm_sync_reg;

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      dx_sync_reg <= 2'h0;
      wm_sync_reg <= 2'h3;
    end else if (CE_I) begin
      dx_sync_reg <= {dx_sync_reg[0], TX_SERIAL_IN_I};
      wm_sync_reg <= {wm_sync_reg[0], WORD_MODE_I};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shift clock divider, high in phases 0 and 1
  logic [PHASE_W-1:0] phase_reg, phase_next;
  logic sclk_reg, sclk_next;
  logic tick;

  always_comb begin
    phase_next = phase_reg + 1'b1;
    sclk_next = ~phase_next[PHASE_W-1];
  end
  // Tick marks the edge where the shift clock rises
  assign tick = (phase_reg == PHASE_W'(SCLK_DIV - 1));

  // Divider restarts from phase zero on reset release
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= '0;
      sclk_reg <= 1'b1;
    end else if (CE_I) begin
      phase_reg <= phase_next;
      sclk_reg <= sclk_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file and APB slave
  logic [CNT_W-1:0] cnt_a_rl_reg [0:1], cnt_a_rl_next [0:1];
  logic [CNT_W-1:0] cnt_b_rl_reg [0:1], cnt_b_rl_next [0:1];
  logic [ADJ_W-1:0] adj_reg [0:1], adj_next [0:1];
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [1:0] adj_pend_reg, adj_pend_next;
  logic [WORD_W-1:0] in_word_reg, in_word_next;
  logic in_new_reg, in_new_next, underrun_reg, underrun_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [1:0] conv_w, filt_w, done_w, pop_w;
  logic [WORD_W-1:0] sh_q [0:1];
  logic buf_in_ready, buf_out_valid, buf_push;
  logic [WORD_W-1:0] buf_out_data;
  logic acc, commit, mapped, out_wr;
  logic [31:0] rd_mux;

  assign acc = PSEL_I & PENABLE_I;
  assign commit = acc & pready_reg;
  assign out_wr = PWRITE_I & (PADDR_I == OFF_OUT_WORD);
  assign buf_push = commit & out_wr;

  // Read mux and decode of the current address
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0;
    case (PADDR_I)
      OFF_TX_CNT_A: rd_mux = 32'(cnt_a_rl_reg[0]);
      OFF_TX_ADJ: rd_mux = 32'(adj_reg[0]);
      OFF_TX_CNT_B: rd_mux = 32'(cnt_b_rl_reg[0]);
      OFF_RX_CNT_A: rd_mux = 32'(cnt_a_rl_reg[1]);
      OFF_RX_ADJ: rd_mux = 32'(adj_reg[1]);
      OFF_RX_CNT_B: rd_mux = 32'(cnt_b_rl_reg[1]);
      OFF_CTRL: rd_mux = 32'(ctrl_reg);
      OFF_ADJ_CMD: rd_mux = 32'(adj_pend_reg);
      OFF_OUT_WORD: rd_mux = 32'h0;
      OFF_IN_WORD: rd_mux = 32'(in_word_reg);
      OFF_STATUS: begin
        rd_mux[ST_IN_NEW] = in_new_reg;
        rd_mux[ST_UNDERRUN] = underrun_reg;
        rd_mux[ST_BUF_FULL] = ~buf_in_ready;
        rd_mux[ST_WORD_PIN] = wm_sync_reg[1];
      end
      default: mapped = 1'b0;
    endcase
  end

  // Next register values; hardware sets win over software clears
  always_comb begin
    cnt_a_rl_next = cnt_a_rl_reg;
    cnt_b_rl_next = cnt_b_rl_reg;
    adj_next = adj_reg;
    ctrl_next = ctrl_reg;
    adj_pend_next = adj_pend_reg & ~filt_w;
    in_word_next = in_word_reg;
    in_new_next = in_new_reg;
    underrun_next = underrun_reg;
    // One wait state; a full buffer holds a data write off
    pready_next = acc & ~pready_reg & (~out_wr | buf_in_ready);
    pslverr_next = pready_next & ~mapped;
    prdata_next = pready_next ? rd_mux : prdata_reg;
    if (commit && PWRITE_I) begin
      case (PADDR_I)
        OFF_TX_CNT_A: cnt_a_rl_next[0] = PWDATA_I[CNT_W-1:0];
        OFF_TX_ADJ: adj_next[0] = PWDATA_I[ADJ_W-1:0];
        OFF_TX_CNT_B: cnt_b_rl_next[0] = PWDATA_I[CNT_W-1:0];
        OFF_RX_CNT_A: cnt_a_rl_next[1] = PWDATA_I[CNT_W-1:0];
        OFF_RX_ADJ: adj_next[1] = PWDATA_I[ADJ_W-1:0];
        OFF_RX_CNT_B: cnt_b_rl_next[1] = PWDATA_I[CNT_W-1:0];
        OFF_CTRL: ctrl_next = PWDATA_I[CTRL_W-1:0];
        OFF_ADJ_CMD: adj_pend_next = adj_pend_next | PWDATA_I[1:0];
        default: ;
      endcase
    end
    if (commit && !PWRITE_I && PADDR_I == OFF_IN_WORD) begin
      in_new_next = 1'b0;
    end
    if (commit && !PWRITE_I && PADDR_I == OFF_STATUS) begin
      underrun_next = 1'b0;
    end
    if (done_w[0]) begin
      in_word_next = sh_q[0];
      in_new_next = 1'b1;
    end
    if (pop_w[1] && !buf_out_valid) begin
      underrun_next = 1'b1;
    end
  end

  // Preset values giving the default conversion rate
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < 2; c++) begin
        cnt_a_rl_reg[c] <= RST_CNT_A;
        cnt_b_rl_reg[c] <= RST_CNT_B;
        adj_reg[c] <= RST_ADJ;
      end
      ctrl_reg <= RST_CTRL;
      adj_pend_reg <= 2'h0;
      in_word_reg <= '0;
      in_new_reg <= 1'b0;
      underrun_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (CE_I) begin
      cnt_a_rl_reg <= cnt_a_rl_next;
      cnt_b_rl_reg <= cnt_b_rl_next;
      adj_reg <= adj_next;
      ctrl_reg <= ctrl_next;
      adj_pend_reg <= adj_pend_next;
      in_word_reg <= in_word_next;
      in_new_reg <= in_new_next;
      underrun_reg <= underrun_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Words queued by software for the receive data output
  stream_buffer #(
    .WIDTH(WORD_W),
    .DEPTH(BUF_DEPTH)
  ) u_out_buf (
    .clk_i(MCLK_I),
    .rst_n_i(rst_n),
    .en_i(CE_I),
    .in_valid_i(buf_push),
    .in_ready_o(buf_in_ready),
    .in_data_i(PWDATA_I[WORD_W-1:0]),
    .out_valid_o(buf_out_valid),
    .out_ready_i(pop_w[1]),
    .out_data_o(buf_out_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Per channel: 0 faces the transmit pins, 1 the receive pins
  logic [1:0] fs_n_q, eod_n_q, strobe_q;
  logic filt_clk_reg, filt_clk_next;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [CNT_W-1:0] cnt_a_reg, cnt_a_next, cnt_b_reg, cnt_b_next, seg_len;
    logic a_wrap, conv_own, conv_use;
    frame_state_t state_reg, state_next;
    logic [BCNT_W-1:0] bcnt_reg, bcnt_next;
    logic [WORD_W-1:0] sh_reg, sh_next;
    logic start_pend_reg, start_pend_next, word_reg, word_next;
    logic fs_n_reg, fs_n_next, eod_n_reg, eod_n_next, strobe_reg;
    logic in_bit, start, done;

    // Master clock divided by A gives filter ticks, those by B conversions
    always_comb begin
      seg_len = cnt_a_rl_reg[c] + (adj_pend_reg[c] ? CNT_W'(adj_reg[c]) : '0);
      a_wrap = (cnt_a_reg <= CNT_W'(1));
      conv_own = a_wrap & (cnt_b_reg <= CNT_W'(1));
      cnt_a_next = a_wrap ? seg_len : cnt_a_reg - 1'b1;
      cnt_b_next = cnt_b_reg;
      if (a_wrap) begin
        cnt_b_next = (cnt_b_reg <= CNT_W'(1)) ? cnt_b_rl_reg[c] : cnt_b_reg - 1'b1;
      end
    end
    // Synchronous mode runs the receive side from transmit timing
    assign conv_use = (c == 1 && ctrl_reg[CTRL_SYNC_BIT]) ? conv_w[0] : conv_own;
    assign conv_w[c] = conv_own;
    assign filt_w[c] = a_wrap;

    // Frame sequencer, stepped once per shift clock
    assign in_bit = (c == 0) ? dx_sync_reg[1] : 1'b0;
    assign start = tick & (state_reg == FR_IDLE) & start_pend_reg;
    always_comb begin
      state_next = state_reg;
      bcnt_next = bcnt_reg;
      sh_next = sh_reg;
      word_next = word_reg;
      done = 1'b0;
      // A pending conversion survives the cycle that consumes the last one
      start_pend_next = conv_use | (start_pend_reg & ~start);
      if (tick) begin
        case (state_reg)
          FR_IDLE: begin
            if (start_pend_reg) begin
              state_next = FR_PRE;
              word_next = wm_sync_reg[1];
              if (c == 1) begin
                sh_next = buf_out_valid ? buf_out_data : '0;
              end
            end
          end
          FR_PRE: begin
            state_next = FR_SHIFT1;
            bcnt_next = word_reg ? BCNT_W'(WORD_W - 1) : BCNT_W'(BYTE_W - 1);
          end
          FR_SHIFT1: begin
            sh_next = {sh_reg[WORD_W-2:0], in_bit};
            bcnt_next = bcnt_reg - 1'b1;
            if (bcnt_reg == '0) begin
              if (word_reg) begin
                state_next = FR_EOD;
                done = 1'b1;
              end else begin
                state_next = FR_GAP;
                bcnt_next = BCNT_W'(GAP_SCLK - 1);
              end
            end
          end
          FR_GAP: begin
            bcnt_next = bcnt_reg - 1'b1;
            if (bcnt_reg == '0) begin
              state_next = FR_SHIFT2;
              bcnt_next = BCNT_W'(BYTE_W - 1);
            end
          end
          FR_SHIFT2: begin
            sh_next = {sh_reg[WORD_W-2:0], in_bit};
            bcnt_next = bcnt_reg - 1'b1;
            if (bcnt_reg == '0) begin
              state_next = FR_IDLE;
              done = 1'b1;
            end
          end
          FR_EOD: state_next = FR_IDLE;
          default: state_next = FR_IDLE;
        endcase
      end
      // Sync low only while bits move; end-of-data low after first part
      fs_n_next = ~(state_next == FR_SHIFT1 || state_next == FR_SHIFT2);
      eod_n_next = ~(state_next == FR_GAP || state_next == FR_SHIFT2 || state_next == FR_EOD);
    end
    assign done_w[c] = done;
    assign pop_w[c] = start;
    assign sh_q[c] = sh_next;
    assign fs_n_q[c] = fs_n_reg;
    assign eod_n_q[c] = eod_n_reg;
    assign strobe_q[c] = strobe_reg;

    // Counters load their presets so frames run straight after reset
    always_ff @(posedge MCLK_I or negedge rst_n) begin
      if (!rst_n) begin
        cnt_a_reg <= RST_CNT_A;
        cnt_b_reg <= RST_CNT_B;
        state_reg <= FR_IDLE;
        bcnt_reg <= '0;
        sh_reg <= '0;
        start_pend_reg <= 1'b0;
        word_reg <= 1'b1;
        fs_n_reg <= 1'b1;
        eod_n_reg <= 1'b1;
        strobe_reg <= 1'b0;
      end else if (CE_I) begin
        cnt_a_reg <= cnt_a_next;
        cnt_b_reg <= cnt_b_next;
        state_reg <= state_next;
        bcnt_reg <= bcnt_next;
        sh_reg <= sh_next;
        start_pend_reg <= start_pend_next;
        word_reg <= word_next;
        fs_n_reg <= fs_n_next;
        eod_n_reg <= eod_n_next;
        strobe_reg <= conv_use;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Filter clock toggles on each transmit filter tick
  assign filt_clk_next = filt_clk_reg ^ filt_w[0];
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      filt_clk_reg <= 1'b0;
    end else if (CE_I) begin
      filt_clk_reg <= filt_clk_next;
    end
  end

  // Every output is a flop
  assign PRDATA_O = prdata_reg;
  assign PREADY_O = pready_reg;
  assign PSLVERR_O = pslverr_reg;
  assign SHIFT_CLK_O = sclk_reg;
  assign TX_FRAME_SYNC_N_O = fs_n_q[0];
  assign RX_FRAME_SYNC_N_O = fs_n_q[1];
  assign TX_END_OF_DATA_N_O = eod_n_q[0];
  assign RX_END_OF_DATA_N_O = eod_n_q[1];
  assign RX_SERIAL_OUT_O = g_ch[1].sh_reg[WORD_W-1];
  assign FILTER_CLK_O = filt_clk_reg;
  assign DAC_STROBE_O = strobe_q[0];
  assign ADC_STROBE_O = strobe_q[1];
endmodule

// ===== bench/codec_timing_checker_assertions.sv
// Port-level checks of the codec timing block.
// Assumes CE_I high, no rate adjust command, synchronous timing.
`timescale 1ns/1ps
module codec_timing_checker (
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [codec_timing_pkg::APB_AW-1:0] PADDR_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic SHIFT_CLK_O,
  input wire logic TX_FRAME_SYNC_N_O,
  input wire logic RX_FRAME_SYNC_N_O,
  input wire logic RX_SERIAL_OUT_O,
  input wire logic TX_END_OF_DATA_N_O,
  input wire logic RX_END_OF_DATA_N_O,
  input wire logic FILTER_CLK_O,
  input wire logic DAC_STROBE_O,
  input wire logic ADC_STROBE_O
);
  import codec_timing_pkg::*;
  logic [7:0] low_cnt;
  logic [15:0] gap_cnt;
  logic seen;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);
  ////////////////////////////////////////////////////////////
  // Sync low time and strobe spacing, long counts kept out of repetitions
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      low_cnt <= 8'h00;
      gap_cnt <= 16'h0000;
      seen <= 1'b0;
    end else begin
      low_cnt <= TX_FRAME_SYNC_N_O ? 8'h00 : low_cnt + 8'h01;
      gap_cnt <= DAC_STROBE_O ? 16'h0001 : gap_cnt + 16'h0001;
      seen <= seen | DAC_STROBE_O;
    end
  end
  ////////////////////////////////////////////////////////////
  property p_sclk_shape;
    $rose(SHIFT_CLK_O) |=> SHIFT_CLK_O ##1 !SHIFT_CLK_O [*2] ##1 SHIFT_CLK_O;
  endproperty
  a_sclk_shape: assert property (p_sclk_shape) else $error("shift clock shape");
  property p_link_edge;
    ($changed(TX_FRAME_SYNC_N_O) || $changed(RX_FRAME_SYNC_N_O) || $changed(RX_SERIAL_OUT_O))
      |-> $rose(SHIFT_CLK_O);
  endproperty
  a_link_edge: assert property (p_link_edge) else $error("link moved off shift edge");
  property p_sync_len;
    $rose(TX_FRAME_SYNC_N_O) |-> (low_cnt == 8'd64) || (low_cnt == 8'd32);
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("sync low length");
  property p_word_eod;
    $rose(TX_FRAME_SYNC_N_O) && low_cnt == 8'd64 |-> !TX_END_OF_DATA_N_O [*4] ##1 TX_END_OF_DATA_N_O;
  endproperty
  a_word_eod: assert property (p_word_eod) else $error("word end pulse");
  property p_byte_gap;
    $rose(TX_FRAME_SYNC_N_O) && low_cnt == 8'd32 && !TX_END_OF_DATA_N_O |-> ##16 $fell(TX_FRAME_SYNC_N_O);
  endproperty
  a_byte_gap: assert property (p_byte_gap) else $error("byte gap width");
  property p_msb_first;
    $fell(RX_FRAME_SYNC_N_O) |-> $stable(RX_SERIAL_OUT_O);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit not ready");
  property p_conv_rate;
    DAC_STROBE_O && seen |-> gap_cnt == 16'd648;
  endproperty
  a_conv_rate: assert property (p_conv_rate) else $error("conversion period");
  property p_auto_start;
    $rose(RST_B_I) |-> ##[1:1000] !TX_FRAME_SYNC_N_O;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("no frame after reset");
  property p_apb_wait;
    PSEL_I && $rose(PENABLE_I) && !(PWRITE_I && PADDR_I == OFF_OUT_WORD) |=> PREADY_O;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("bus answer late");
  property p_err_ready;
    PSLVERR_O |-> PREADY_O && $past(PSEL_I && PENABLE_I);
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without answer");
  // Synchronous mode: receive pins mirror transmit timing exactly
  property p_sync_twin;
    (TX_FRAME_SYNC_N_O == RX_FRAME_SYNC_N_O) && (TX_END_OF_DATA_N_O == RX_END_OF_DATA_N_O)
      && (DAC_STROBE_O == ADC_STROBE_O);
  endproperty
  a_sync_twin: assert property (p_sync_twin) else $error("receive timing not tied to transmit");
  // Filter clock half period equals the counter A preset
  property p_filt_period;
    $changed(FILTER_CLK_O) |=> $stable(FILTER_CLK_O) [*8] ##10 $changed(FILTER_CLK_O);
  endproperty
  a_filt_period: assert property (p_filt_period) else $error("filter clock period");
endmodule

bind codec_serial_timing_reset codec_timing_checker codec_timing_checker_i (.MCLK_I, .RST_B_I,
  .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PREADY_O, .PSLVERR_O, .SHIFT_CLK_O,
  .TX_FRAME_SYNC_N_O, .RX_FRAME_SYNC_N_O, .RX_SERIAL_OUT_O, .TX_END_OF_DATA_N_O, .RX_END_OF_DATA_N_O,
  .FILTER_CLK_O, .DAC_STROBE_O, .ADC_STROBE_O);

// ===== bench/host_serial_port.sv
// Behavioural host serial port on the far side of the link.
// Assumes the device owns the shift clock and both syncs.
`timescale 1ns/1ps
module host_serial_port (
  input wire logic sclk_i,
  input wire logic tx_fs_n_i,
  input wire logic tx_eod_n_i,
  input wire logic rx_fs_n_i,
  input wire logic rx_eod_n_i,
  input wire logic rx_dat_i,
  input wire logic [15:0] send_i,
  output logic tx_dat_o,
  output logic [15:0] got_o,
  output logic [15:0] frames_o
);
  int tb = 0;
  int rb = 0;
  logic [15:0] sh = 16'h0000;
  initial begin
    tx_dat_o = 1'b0;
    got_o = 16'h0000;
    frames_o = 16'h0000;
  end
  ////////////////////////////////////////////////////////////
  // Launch after the rise, MSB first; between frames the line wanders
  always @(posedge sclk_i) begin
    #1;
    if (!tx_fs_n_i && tb < 16) begin
      tx_dat_o = send_i[15-tb];
      tb++;
    end else begin
      tx_dat_o = ~tx_dat_o;
    end
    if (tx_fs_n_i && tx_eod_n_i) tb = 0;
  end
  // Sample mid-period, sixteen bits make a word in either mode
  always @(negedge sclk_i) begin
    if (!rx_fs_n_i && rb < 16) begin
      sh = {sh[14:0], rx_dat_i};
      rb++;
      if (rb == 16) begin
        got_o = sh;
        frames_o++;
      end
    end
    if (rx_fs_n_i && rx_eod_n_i) rb = 0;
  end
endmodule

// ===== bench/tb_codec_serial_timing_reset.sv
// Self-checking bench for the codec timing block.
// Assumes the host port model and the bound checker.
`timescale 1ns/1ps
module tb_codec_serial_timing_reset;
  import codec_timing_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, word_mode = 1'b1, tx_ser, sclk, tx_fs_n, rx_fs_n, rx_ser, tx_eod_n, rx_eod_n;
  logic [15:0] send = 16'h0000;
  logic [15:0] got, frames;
  logic [15:0] w [3];
  logic [31:0] rd, av;
  logic er;
  logic [7:0] a;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  codec_serial_timing_reset codec_serial_timing_reset_i (.MCLK_I(clk), .RST_B_I(rst_n), .CE_I(1'b1),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .WORD_MODE_I(word_mode),
    .TX_SERIAL_IN_I(tx_ser), .SHIFT_CLK_O(sclk), .TX_FRAME_SYNC_N_O(tx_fs_n), .RX_FRAME_SYNC_N_O(rx_fs_n),
    .RX_SERIAL_OUT_O(rx_ser), .TX_END_OF_DATA_N_O(tx_eod_n), .RX_END_OF_DATA_N_O(rx_eod_n),
    .FILTER_CLK_O(), .DAC_STROBE_O(), .ADC_STROBE_O());
  host_serial_port host_serial_port_i (.sclk_i(sclk), .tx_fs_n_i(tx_fs_n), .tx_eod_n_i(tx_eod_n),
    .rx_fs_n_i(rx_fs_n), .rx_eod_n_i(rx_eod_n), .rx_dat_i(rx_ser), .send_i(send), .tx_dat_o(tx_ser),
    .got_o(got), .frames_o(frames));
  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; the wait has no fixed length, the run timeout bounds it
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Width mask of a writable receive timing register
  function automatic logic [31:0] wmask(input logic [7:0] ad);
    return (ad == OFF_RX_ADJ) ? 32'h3f : 32'hff;
  endfunction
  // Waits for the host to finish taking one more word
  task automatic wait_frame;
    logic [15:0] c;
    c = frames;
    while (frames === c) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask
  // One word each way, then both ends compared
  task automatic xchg(input logic [15:0] dw, input logic [15:0] hw);
    apb(1'b1, OFF_OUT_WORD, 32'(dw));
    send <= hw;
    wait_frame();
    chk("link word", 32'(dw), 32'(got));
    apb(1'b0, OFF_IN_WORD, 32'h0);
    chk("in word", 32'(hw), rd);
  endtask
  ////////////////////////////////////////////////////////////
  // Hang guard, well above some fourteen frames
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(28708));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset presets: 648 master clocks a conversion, adjust of one
    for (int i = 0; i < 2; i++) begin
      a = 8'(12 * i);
      apb(1'b0, a, 32'h0);
      av = rd;
      apb(1'b0, a + 8'h08, 32'h0);
      chk("rate product", 32'd648, av * rd);
      apb(1'b0, a + 8'h04, 32'h0);
      chk("rate adjust", 32'h1, rd);
    end
    apb(1'b0, OFF_CTRL, 32'h0);
    chk("control", 32'he4, rd);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped error", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, rd);
    // Receive timing registers, idle while synchronous
    for (int i = 0; i < 6; i++) begin
      a = OFF_RX_CNT_A + 8'(4 * (i % 3));
      av = $urandom;
      apb(1'b1, a, av);
      apb(1'b0, a, 32'h0);
      chk("rx register", av & wmask(a), rd);
    end
    wait_frame();
    chk("idle word", 32'h0, 32'(got));
    // Mode set before each frame, both modes first
    for (int i = 0; i < 8; i++) begin
      word_mode <= (i < 2) ? i[0] : 1'($urandom);
      xchg(16'($urandom), 16'($urandom));
    end
    // Fill the buffer; third write is held until the link pops
    for (int i = 0; i < 3; i++) w[i] = 16'($urandom);
    apb(1'b1, OFF_OUT_WORD, 32'(w[0]));
    apb(1'b1, OFF_OUT_WORD, 32'(w[1]));
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("buffer full", 32'h1, 32'(rd[ST_BUF_FULL]));
    apb(1'b1, OFF_OUT_WORD, 32'(w[2]));
    for (int i = 0; i < 3; i++) begin
      wait_frame();
      chk("queued word", 32'(w[i]), 32'(got));
    end
    wait_frame();
    chk("drained word", 32'h0, 32'(got));
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("underrun", 32'h1, 32'(rd[ST_UNDERRUN]));
    // Reset in mid-run brings presets and frames back
    apb(1'b1, OFF_RX_ADJ, 32'h2a);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, OFF_RX_ADJ, 32'h0);
    chk("adjust after reset", 32'h1, rd);
    wait_frame();
    chk("restart word", 32'h0, 32'(got));
    tally_and_finish();
  end
endmodule
